// >>> ppsd_pkg.sv
// shared constants, types and helper functions of the point plot stream decoder
package ppsd_pkg;

   // command words
   localparam logic [7:0] CODE_PLOT   = 8'h02;  // general plot entry
   localparam logic [7:0] CODE_SEL_LO = 8'hF0;  // lowest submode selection code
   localparam logic [7:0] CODE_CHAR   = 8'hFE;  // character plot submode
   localparam logic [7:0] CODE_XPT    = 8'hFD;  // absolute x point submode
   localparam logic [7:0] CODE_YPT    = 8'hFC;  // absolute y point submode
   localparam logic [7:0] CODE_INC    = 8'hFB;  // incremental submode
   localparam logic [7:0] CODE_ESC    = 8'hFF;  // leave plot mode

   // grid geometry
   localparam logic [7:0] GRID_W   = 8'hA0;     // 160 blocks across
   localparam logic [7:0] GRID_H25 = 8'h64;     // 100 blocks high, 25-line format
   localparam logic [7:0] GRID_H48 = 8'hC0;     // 192 blocks high, 48-line format
   localparam logic [6:0] CELLS_W  = 7'h50;     // 80 cells per row
   localparam logic [5:0] ROWS25   = 6'h19;     // 25 rows
   localparam logic [5:0] ROWS48   = 6'h30;     // 48 rows
   localparam int         COLOR_W  = 3;

   // reset values
   localparam logic [7:0] X_RST = 8'h00;
   localparam logic [7:0] Y_RST = 8'h00;

   typedef enum logic [5:0] {
      SM_OFF   = 6'b00_0001,
      SM_XPT   = 6'b00_0010,
      SM_YPT   = 6'b00_0100,
      SM_INC   = 6'b00_1000,
      SM_OTHER = 6'b01_0000,
      SM_CHAR  = 6'b10_0000
   } ppsd_sub_t;

   typedef enum logic [3:0] {
      RMW_IDLE = 4'b0001,
      RMW_RD   = 4'b0010,
      RMW_MRG  = 4'b0100,
      RMW_WR   = 4'b1000
   } ppsd_rmw_t;

   // one display cell: graphic flag, colour and block pattern
   typedef struct packed {
      logic               gfx;
      logic [COLOR_W-1:0] color;
      logic [7:0]         pattern;
   } ppsd_cell_t;

   // a block position on the plot grid
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
   } ppsd_pos_t;

   // fold an out-of-range coordinate back into the grid
   function automatic logic [7:0] ppsd_wrap(input logic [7:0] v, input logic [7:0] lim);
      logic [7:0] r;
      r = v;
      if (r >= lim) r = r - lim;
      if (r >= lim) r = r - lim;
      return r;
   endfunction

   // one signed step from a two-bit pair, wrapping at the grid edge
   function automatic logic [7:0] ppsd_step(input logic [7:0] p, input logic [1:0] pr,
                                            input logic [7:0] lim);
      logic [7:0] r;
      r = p;
      if (pr == 2'b10) r = (p == lim - 8'h01) ? 8'h00 : p + 8'h01;
      if (pr == 2'b01) r = (p == 8'h00) ? lim - 8'h01 : p - 8'h01;
      return r;
   endfunction

   // linear cell address, row 0 at the top of the screen
   function automatic logic [11:0] ppsd_addr(input logic [6:0] col, input logic [5:0] row);
      return 12'(row) * 12'(CELLS_W) + 12'(col);             // widen before the product
   endfunction

endpackage

// >>> ppsd_blockmap.sv
// maps a grid block position to its cell column, row and block bit
`timescale 1ns/1ps
module ppsd_blockmap
   import ppsd_pkg::*;
(
   input  wire ppsd_pos_t  pos_in,
   input  wire logic       line48_in,
   output logic [6:0]      col_out,
   output logic [5:0]      row_out,
   output logic [2:0]      bit_out
);
   logic [5:0] rows;

   // two blocks across, four high per cell, origin at the lower left
   assign rows    = line48_in ? ROWS48 : ROWS25;
   assign col_out = pos_in.x[7:1];
   assign row_out = rows - 6'h01 - pos_in.y[7:2];
   assign bit_out = {pos_in.y[1:0], pos_in.x[0]};
endmodule

// >>> ppsd_cell_rmw.sv
// read-modify-write of one display cell to light or toggle a block
`timescale 1ns/1ps
module ppsd_cell_rmw
   import ppsd_pkg::*;
(
   input  wire logic               sys_clk_in,
   input  wire logic               sys_rst_in,
   input  wire logic               req_in,
   input  wire logic [11:0]        addr_in,
   input  wire logic [7:0]         mask_in,
   input  wire logic               xor_in,
   input  wire logic [COLOR_W-1:0] color_in,
   output logic                    busy_out,
   output logic                    mem_rd_out,
   output logic                    mem_wr_out,
   output logic [11:0]             mem_addr_out,
   output ppsd_cell_t              mem_wdata_out,
   input  wire ppsd_cell_t         mem_rdata_in
);
   ppsd_rmw_t  st_r, st_nxt;
   logic [7:0] mask_r;
   logic       xor_r;
   ppsd_cell_t merged;

   // a text cell is replaced outright; a graphic cell is or-ed or toggled
   assign merged.gfx     = 1'b1;
   assign merged.color   = color_in;
   assign merged.pattern = !mem_rdata_in.gfx ? mask_r :
                           xor_r ? (mem_rdata_in.pattern ^ mask_r) :
                           (mem_rdata_in.pattern | mask_r);
   assign busy_out   = (st_r != RMW_IDLE);
   assign mem_rd_out = (st_r == RMW_RD);
   assign mem_wr_out = (st_r == RMW_WR);

   // sequence idle, read, merge, write
   always_comb begin
      case (st_r)
         RMW_IDLE: st_nxt = req_in ? RMW_RD : RMW_IDLE;
         RMW_RD:   st_nxt = RMW_MRG;
         RMW_MRG:  st_nxt = RMW_WR;
         default:  st_nxt = RMW_IDLE;
      endcase
   end

   // state and captured operands
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         st_r          <= RMW_IDLE;
         mask_r        <= 8'h00;
         xor_r         <= 1'b0;
         mem_addr_out  <= 12'h000;
         mem_wdata_out <= '0;
      end else begin
         st_r <= st_nxt;
         if (st_r == RMW_IDLE && req_in) begin
            mask_r       <= mask_in;
            xor_r        <= xor_in;
            mem_addr_out <= addr_in;
         end
         if (st_r == RMW_MRG) mem_wdata_out <= merged;
      end
   end

   sequence rmw_walk_s;
      mem_rd_out ##1 (!mem_rd_out && !mem_wr_out) ##1 mem_wr_out;
   endsequence

   rmw_order_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (st_r == RMW_IDLE && req_in) |=> rmw_walk_s)
      else $error("cell update did not read then write");
endmodule

// >>> ppsd_decoder.sv
// plot point stream decoder: point and incremental plot submodes
`timescale 1ns/1ps
// How it works
// - code 2 enters plot mode directly in the x point submode
// - x point data is the x coordinate; above 159 has 160 subtracted
// - an x coordinate is only stored, then the y point submode follows
// - a y coordinate lights the block at stored x, then back to x point
// - a y above range is reduced by 100 (twice above 199), or 192 on 48 lines
// - word 255 leaves submode and plot mode; code 2 is needed again
// - words 240 to 254 in point submodes select a submode, never data
// - 253 selects x point, 252 y point, 251 incremental, except from character plot
// - a directly selected y point plots with the x still held
// - grid is 160 by 100 or 192; a text cell becomes a block cell
// - incremental word holds two x,y step pairs: 10 plus, 01 minus, else none
// - zero low nibble moves by the first step only and lights nothing
// - the incremental submode stays selected after each change word
// - erase flag at entry makes plotting toggle blocks by exclusive-or
// - each cell is two blocks across, four high, origin lower left
module ppsd_decoder
   import ppsd_pkg::*;
(
   input  wire logic               sys_clk_in,
   input  wire logic               sys_rst_in,
   input  wire logic [7:0]         word_in,
   input  wire logic               word_valid_in,
   output logic                    word_ready_out,
   input  wire logic               line48_in,
   input  wire logic               erase_in,
   input  wire logic [COLOR_W-1:0] color_in,
   output logic                    mem_rd_out,
   output logic                    mem_wr_out,
   output logic [11:0]             mem_addr_out,
   output ppsd_cell_t              mem_wdata_out,
   input  wire ppsd_cell_t         mem_rdata_in,
   output logic                    plot_mode_out,
   output ppsd_sub_t               submode_out
);
   ppsd_sub_t  sub_r, sub_nxt;
   ppsd_pos_t  cur_r, cur_nxt;     // stored x and y
   ppsd_pos_t  plot_r, plot_nxt;   // block being drawn
   logic       plot_req_r, plot_req_nxt;
   logic       erase_r, erase_nxt;
   logic       pend_r, pend_nxt;   // second incremental step still owed
   logic [3:0] pend_pair_r, pend_pair_nxt;

   logic       take;
   logic       is_code;
   logic       is_esc;
   logic       is_point_sub;
   logic       rmw_busy;
   logic       issue2;
   logic [7:0] ymax;
   logic [7:0] xw;
   logic [7:0] yw;
   ppsd_pos_t  step1;
   ppsd_pos_t  step2;
   ppsd_sub_t  sel_sub;
   logic [6:0] blk_col;
   logic [5:0] blk_row;
   logic [2:0] blk_bit;

   // word classification and derived positions
   assign take         = word_valid_in & word_ready_out;
   assign is_code      = (word_in >= CODE_SEL_LO);
   assign is_esc       = (word_in == CODE_ESC);
   assign is_point_sub = (sub_r != SM_OFF) && (sub_r != SM_CHAR);
   assign ymax         = line48_in ? GRID_H48 : GRID_H25;
   assign xw           = ppsd_wrap(word_in, GRID_W);
   assign yw           = ppsd_wrap(word_in, ymax);
   assign step1.x      = ppsd_step(cur_r.x, word_in[7:6], GRID_W);
   assign step1.y      = ppsd_step(cur_r.y, word_in[5:4], ymax);
   assign step2.x      = ppsd_step(cur_r.x, pend_pair_r[3:2], GRID_W);
   assign step2.y      = ppsd_step(cur_r.y, pend_pair_r[1:0], ymax);

   // selection code to submode
   assign sel_sub = (word_in == CODE_XPT)  ? SM_XPT :
                    (word_in == CODE_YPT)  ? SM_YPT :
                    (word_in == CODE_INC)  ? SM_INC :
                    (word_in == CODE_CHAR) ? SM_CHAR : SM_OTHER;

   // words wait while a block is being drawn
   assign issue2         = pend_r & ~rmw_busy & ~plot_req_r;
   assign word_ready_out = ~rmw_busy & ~plot_req_r & ~pend_r;
   assign plot_mode_out  = (sub_r != SM_OFF);
   assign submode_out    = sub_r;

   // submode sequencing and coordinate updates
   always_comb begin
      sub_nxt       = sub_r;
      cur_nxt       = cur_r;
      plot_nxt      = plot_r;
      plot_req_nxt  = 1'b0;
      erase_nxt     = erase_r;
      pend_nxt      = pend_r;
      pend_pair_nxt = pend_pair_r;
      if (issue2) begin
         cur_nxt      = step2;
         plot_nxt     = step2;
         plot_req_nxt = 1'b1;
         pend_nxt     = 1'b0;
      end else if (take) begin
         case (sub_r)
            SM_OFF: begin
               if (word_in == CODE_PLOT) begin
                  sub_nxt   = SM_XPT;
                  erase_nxt = erase_in;
               end
            end
            SM_CHAR: begin
               if (is_esc) sub_nxt = SM_OFF;
            end
            default: begin
               if (is_esc) begin
                  sub_nxt = SM_OFF;
               end else if (is_code) begin
                  sub_nxt = sel_sub;
               end else if (sub_r == SM_XPT) begin
                  cur_nxt.x = xw;
                  sub_nxt   = SM_YPT;
               end else if (sub_r == SM_YPT) begin
                  cur_nxt.y    = yw;
                  plot_nxt     = '{x: cur_r.x, y: yw};
                  plot_req_nxt = 1'b1;
                  sub_nxt      = SM_XPT;
               end else if (sub_r == SM_INC) begin
                  cur_nxt = step1;
                  if (word_in[3:0] != 4'h0) begin
                     plot_nxt      = step1;
                     plot_req_nxt  = 1'b1;
                     pend_nxt      = 1'b1;
                     pend_pair_nxt = word_in[3:0];
                  end
               end
            end
         endcase
      end
   end

   // decoder state registers
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         sub_r       <= SM_OFF;
         cur_r       <= '{x: X_RST, y: Y_RST};
         plot_r      <= '{x: X_RST, y: Y_RST};
         plot_req_r  <= 1'b0;
         erase_r     <= 1'b0;
         pend_r      <= 1'b0;
         pend_pair_r <= 4'h0;
      end else begin
         sub_r       <= sub_nxt;
         cur_r       <= cur_nxt;
         plot_r      <= plot_nxt;
         plot_req_r  <= plot_req_nxt;
         erase_r     <= erase_nxt;
         pend_r      <= pend_nxt;
         pend_pair_r <= pend_pair_nxt;
      end
   end

   // block position to cell address and bit
   ppsd_blockmap u_map (
      .pos_in    (plot_r),
      .line48_in (line48_in),
      .col_out   (blk_col),
      .row_out   (blk_row),
      .bit_out   (blk_bit)
   );

   // cell update engine
   ppsd_cell_rmw u_rmw (
      .sys_clk_in    (sys_clk_in),
      .sys_rst_in    (sys_rst_in),
      .req_in        (plot_req_r),
      .addr_in       (ppsd_addr(blk_col, blk_row)),
      .mask_in       (8'h01 << blk_bit),
      .xor_in        (erase_r),
      .color_in      (color_in),
      .busy_out      (rmw_busy),
      .mem_rd_out    (mem_rd_out),
      .mem_wr_out    (mem_wr_out),
      .mem_addr_out  (mem_addr_out),
      .mem_wdata_out (mem_wdata_out),
      .mem_rdata_in  (mem_rdata_in)
   );

   // checks on the decoder
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   logic was_rst_r;
   always_ff @(posedge sys_clk_in) was_rst_r <= sys_rst_in;

   sequence data_in_s(ppsd_sub_t s);
      take && sub_r == s && !is_code;
   endsequence

   reset_off_a: assert property (was_rst_r |-> sub_r == SM_OFF && !plot_req_r)
      else $error("plot mode not off after reset");

   entry_xpt_a: assert property (take && sub_r == SM_OFF && word_in == CODE_PLOT
      |=> sub_r == SM_XPT && erase_r == $past(erase_in))
      else $error("plot entry did not select x point");

   x_store_a: assert property (data_in_s(SM_XPT) |=> sub_r == SM_YPT
      && !plot_req_r && cur_r.x == ppsd_wrap($past(word_in), GRID_W) && cur_r.x < GRID_W)
      else $error("x coordinate not stored alone");

   y_plot_a: assert property (data_in_s(SM_YPT) |=> plot_req_r && sub_r == SM_XPT
      && plot_r.x == $past(cur_r.x) && plot_r.y == cur_r.y ##1 mem_rd_out ##2 mem_wr_out)
      else $error("y coordinate did not light a block");

   y_range_a: assert property (plot_req_r |-> plot_r.y < ymax && plot_r.x < GRID_W)
      else $error("plotted block off the grid");

   esc_exit_a: assert property (take && sub_r != SM_OFF && is_esc
      |=> sub_r == SM_OFF && !plot_mode_out)
      else $error("escape did not leave plot mode");

   sel_code_a: assert property (take && is_point_sub && is_code && !is_esc
      |=> !plot_req_r && cur_r == $past(cur_r) && sub_r == $past(sel_sub))
      else $error("selection code treated as data");

   inc_stay_a: assert property (data_in_s(SM_INC)
      |=> (sub_r == SM_INC || $past(take && is_code)) [*3])
      else $error("incremental submode left");

   inc_blank_a: assert property (data_in_s(SM_INC) && word_in[3:0] == 4'h0
      |=> !plot_req_r && !pend_r && cur_r == $past(step1))
      else $error("blank increment lit a block");

   inc_two_a: assert property (data_in_s(SM_INC) && word_in[3:0] != 4'h0
      |=> plot_req_r && plot_r == $past(step1) ##[1:6] plot_req_r && !pend_r)
      else $error("incremental word did not plot two blocks");

   // steps of one cell update as seen from the decoder
   sequence upd_walk_s;
      mem_rd_out ##2 mem_wr_out;
   endsequence

   // a block still owed or being drawn
   sequence owed_s;
      plot_req_r || pend_r || rmw_busy;
   endsequence

   // no word is taken while a plot is owed
   ready_hold_a: assert property (owed_s |-> !word_ready_out)
      else $error("word accepted while drawing");

   // every plot request starts one cell update
   req_walk_a: assert property (plot_req_r |=> upd_walk_s)
      else $error("plot request did not update a cell");

   // a written cell is a block cell in the colour of its merge cycle
   wr_cell_a: assert property (mem_wr_out |-> mem_wdata_out.gfx
      && mem_wdata_out.color == $past(color_in))
      else $error("written cell not a coloured block cell");

   // without erase the drawn block is always lit
   wr_lit_a: assert property (mem_wr_out && !erase_r |-> mem_wdata_out.pattern != 8'h00)
      else $error("written cell has no lit block");

   // a second step is only owed in the incremental submode
   inc_owed_a: assert property (pend_r |-> sub_r == SM_INC)
      else $error("second step owed outside incremental");

   // the second step moves from the first and is plotted
   step_two_a: assert property (issue2 |=> plot_req_r && plot_r == $past(step2))
      else $error("second step not plotted");

   // data words in the other submodes neither move nor light anything
   other_idle_a: assert property (take && sub_r == SM_OTHER && !is_code
      |=> sub_r == SM_OTHER && !plot_req_r && cur_r == $past(cur_r))
      else $error("data in other submode acted on");

   // character plot leaves only on the escape word
   char_hold_a: assert property (take && sub_r == SM_CHAR && !is_esc
      |=> sub_r == SM_CHAR && !plot_req_r)
      else $error("character plot left without escape");

   // outside plot mode only the entry code counts
   off_ignore_a: assert property (take && sub_r == SM_OFF && word_in != CODE_PLOT
      |=> sub_r == SM_OFF && !plot_req_r)
      else $error("word acted on outside plot mode");

   // leaving plot mode keeps the stored position
   exit_keep_a: assert property (take && is_esc |=> cur_r == $past(cur_r))
      else $error("escape changed the stored position");

   // the erase flag changes only on plot entry
   erase_keep_a: assert property (!(take && sub_r == SM_OFF)
      |=> erase_r == $past(erase_r))
      else $error("erase flag changed inside plot mode");

   // a drawn cell always lies on the screen
   addr_range_a: assert property (mem_rd_out |-> mem_addr_out < 12'hF00)
      else $error("cell address off the screen");
endmodule

// >>> ppsd_mem_model.sv
// display cell memory on the far side of the decoder, one-cycle read latency
`timescale 1ns/1ps
module ppsd_mem_model
   import ppsd_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        mem_rd_in,
   input  wire logic        mem_wr_in,
   input  wire logic [11:0] mem_addr_in,
   input  wire ppsd_cell_t  mem_wdata_in,
   output ppsd_cell_t       mem_rdata_out
);
   ppsd_cell_t mem [0:3839];
   int         wr_cnt = 0;

   initial mem_rdata_out = '0;

   // read data is valid only in the cycle after a read, otherwise it toggles
   always @(posedge sys_clk_in) begin
      if (mem_rd_in && mem_addr_in < 12'hF00) begin
         mem_rdata_out <= mem[mem_addr_in];
      end else begin
         mem_rdata_out <= ~mem_rdata_out;
      end
      if (mem_wr_in) begin
         wr_cnt <= wr_cnt + 1;
         if (mem_addr_in < 12'hF00) begin
            mem[mem_addr_in] <= mem_wdata_in;
         end
      end
   end
endmodule

// >>> test_plot_point_stream_decoder.sv
// self-checking bench for the point plot stream decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module test_plot_point_stream_decoder
   import ppsd_pkg::*;
;
   logic                sys_clk_in    = 1'b0;
   logic                sys_rst_in    = 1'b1;
   logic [7:0]          word_in       = 8'h00;
   logic                word_valid_in = 1'b0;
   logic                line48_in     = 1'b0;
   logic                erase_in      = 1'b0;
   logic [COLOR_W-1:0]  color_in      = '0;
   logic                word_ready_out;
   logic                mem_rd_out;
   logic                mem_wr_out;
   logic [11:0]         mem_addr_out;
   ppsd_cell_t          mem_wdata_out;
   ppsd_cell_t          mem_rdata_in;
   logic                plot_mode_out;
   ppsd_sub_t           submode_out;
   int                  fails = 0;
   int                  total_checks = 0;
   int                  cycles = 0;
   // reference model state: mode 0 off, 1 x, 2 y, 3 incremental, 4 other, 5 character
   int                  m_mode, m_x, m_y, m_plots;
   logic                m_erase;
   ppsd_cell_t          em [0:3839];
   int                  touched [$];
   int                  pts [12] = '{0, 0, 159, 99, 160, 100, 239, 239, 1, 200, 200, 3};

   ppsd_decoder ppsd_decoder_inst (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .word_in(word_in),
      .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
      .line48_in(line48_in), .erase_in(erase_in), .color_in(color_in),
      .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
      .plot_mode_out(plot_mode_out), .submode_out(submode_out));

   ppsd_mem_model ppsd_mem_model_inst (
      .sys_clk_in(sys_clk_in), .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
      .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_rdata_out(mem_rdata_in));

   // clock and hang guard
   initial forever #5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   function automatic int wrap(int v, int lim);
      while (v >= lim) v -= lim;
      return v;
   endfunction

   // one step of a two-bit pair, wrapping at the grid edge
   function automatic int step(int p, int pr, int lim);
      if (pr == 2) return (p == lim - 1) ? 0 : p + 1;
      if (pr == 1) return (p == 0) ? lim - 1 : p - 1;
      return p;
   endfunction

   // light the current block in the reference memory
   task automatic plot();
      int         a, b;
      ppsd_cell_t c;
      a = ((line48_in ? 48 : 25) - 1 - m_y / 4) * 80 + m_x / 2;
      b = (m_y % 4) * 2 + m_x % 2;
      c = em[a];
      if (!c.gfx) c.pattern = 8'h00;
      if (m_erase) c.pattern = c.pattern ^ (8'h01 << b);
      else c.pattern = c.pattern | (8'h01 << b);
      c.gfx = 1'b1;
      c.color = color_in;
      em[a] = c;
      touched.push_back(a);
      m_plots++;
   endtask

   // reference interpretation of one accepted word
   task automatic model_word(int w);
      int lim;
      lim = line48_in ? 192 : 100;
      if (m_mode == 0) begin
         if (w == 2) begin
            m_mode = 1;
            m_erase = erase_in;
         end
      end else if (w == 255) begin
         m_mode = 0;
      end else if (m_mode == 5) begin
      end else if (w >= 240) begin
         m_mode = (w == 253) ? 1 : (w == 252) ? 2 : (w == 251) ? 3 : (w == 254) ? 5 : 4;
      end else if (m_mode == 1) begin
         m_x = wrap(w, 160);
         m_mode = 2;
      end else if (m_mode == 2) begin
         m_y = wrap(w, lim);
         plot();
         m_mode = 1;
      end else if (m_mode == 3) begin
         m_x = step(m_x, w >> 6, 160);
         m_y = step(m_y, (w >> 4) & 3, lim);
         if ((w & 15) != 0) begin
            plot();
            m_x = step(m_x, (w >> 2) & 3, 160);
            m_y = step(m_y, w & 3, lim);
            plot();
         end
      end
   endtask

   // offer one word, wait for it to be taken and finished, then compare
   task automatic send(int w);
      int n, a;
      n = 0;
      @(negedge sys_clk_in);
      word_in = 8'(w);
      word_valid_in = 1'b1;
      color_in = COLOR_W'($urandom);
      while (word_ready_out !== 1'b1 && n < 40) begin
         @(negedge sys_clk_in);
         n++;
      end
      @(posedge sys_clk_in);
      model_word(w);
      @(negedge sys_clk_in);
      word_valid_in = 1'b0;
      n = 0;
      while ((word_ready_out !== 1'b1 || ppsd_mem_model_inst.wr_cnt != m_plots) && n < 40) begin
         @(negedge sys_clk_in);
         n++;
      end
      `CHK("write count", m_plots, ppsd_mem_model_inst.wr_cnt)
      `CHK("submode", 6'(1 << m_mode), submode_out)
      `CHK("plot mode", 1'(m_mode != 0), plot_mode_out)
      while (touched.size() > 0) begin
         a = touched.pop_front();
         `CHK("cell", em[a], ppsd_mem_model_inst.mem[a])
      end
   endtask

   initial begin
      void'($urandom(32'h0000_9206));
      m_mode = 0;
      m_x = 0;
      m_y = 0;
      m_plots = 0;
      m_erase = 1'b0;
      // text and graphic cells mixed so replacement and merging both occur
      for (int i = 0; i < 3840; i++) begin
         em[i] = ppsd_cell_t'($urandom);
         ppsd_mem_model_inst.mem[i] = em[i];
      end
      repeat (12) @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      `CHK("reset submode", SM_OFF, submode_out)
      `CHK("reset ready", 1'b1, word_ready_out)
      // words outside plot mode are ignored
      send(253); send(7); send(255); send(0);
      $display("test idle done");
      // absolute points at and beyond the range limits, 253 as filler
      send(2);
      for (int i = 0; i < 12; i += 2) begin
         send(pts[i]); send(pts[i + 1]); send(253);
      end
      $display("test points done");
      // direct y selection plots with the held x, then random pairs
      send(252); send(57); send(252); send(98);
      repeat (20) begin
         send($urandom % 240); send($urandom % 240);
      end
      $display("test y select done");
      // incremental: edge wrap, zero low nibble, every change word
      send(253); send(0); send(0); send(251);
      send(8'h50); send(8'hA0); send(8'hAA); send(251); send(8'h55);
      for (int w = 0; w < 240; w++) send(w);
      $display("test incremental done");
      // every selection code from a point submode, with data after it
      for (int c = 240; c <= 254; c++) begin
         send(253); send(c); send(40);
      end
      send(253); send(251); send(255); send(251); send(2);
      $display("test selection done");
      // erase flag: the same block twice removes it
      send(255);
      erase_in = 1'b1;
      send(2); send(30); send(40); send(30); send(40);
      send(251); send(8'h88); send(8'h44);
      send(255);
      erase_in = 1'b0;
      $display("test erase done");
      // 48-line format with a random word stream
      line48_in = 1'b1;
      send(2);
      repeat (150) send($urandom % 256);
      $display("test random done");
      // reset in mid-run clears mode and coordinates
      @(negedge sys_clk_in);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      `CHK("mid reset submode", SM_OFF, submode_out)
      line48_in = 1'b0;
      m_mode = 0;
      m_x = 0;
      m_y = 0;
      send(2); send(252); send(3);
      $display("test reset done");
      stop_test();
   end
endmodule
